// file: hw/primary_side_control.sv
// primary bus sideband control: lock, parity, system error, request
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module primary_side_control #(
  parameter int ADDR_W = 8
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              primary_reset_n,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [31:0]       reg_rdata,
  input  wire logic [31:0]       primary_ad,
  input  wire logic [3:0]        primary_cmd_byte_en,
  input  wire logic              primary_parity,
  input  wire logic              primary_frame_n,
  input  wire logic              primary_irdy_n,
  input  wire logic              primary_trdy_n,
  input  wire logic              primary_config_select,
  input  wire logic              primary_grant_n,
  input  wire logic              receiving_data,
  input  wire logic              bus_request,
  input  wire logic              master_active,
  input  wire logic              lock_request,
  input  wire logic              posted_write_parity_err,
  input  wire logic              posted_write_master_abort,
  input  wire logic              posted_write_target_abort,
  input  wire logic              posted_write_discarded,
  input  wire logic              delayed_write_discarded,
  input  wire logic              delayed_read_discarded,
  input  wire logic              delayed_master_timeout,
  input  wire logic              secondary_system_err_n,
  input  wire logic              primary_speed_enable,
  input  wire logic              speed_config_strap,
  input  wire logic              clock_mode_sync,
  output logic                   primary_lock_n,
  output logic                   primary_lock_oe,
  output logic                   primary_data_parity_err_n,
  output logic                   primary_data_parity_err_oe,
  output logic                   primary_system_err_n,
  output logic                   primary_system_err_oe,
  output logic                   primary_request_n,
  output logic                   primary_request_oe,
  output logic                   primary_park_oe,
  output logic                   config_claim,
  output logic                   secondary_speed_enable,
  output logic                   secondary_speed_enable_oe,
  output logic                   status_cap66
);
  typedef struct packed {
    pci_side_pkg::lock_state_t               lock_st;
    logic                                    lock_n;
    logic                                    lock_oe;
    logic                                    perr_n;
    logic                                    perr_oe;
    logic                                    chk_valid;
    logic                                    chk_addr;
    logic [31:0]                             chk_ad;
    logic [3:0]                              chk_cbe;
    logic                                    serr_oe;
    logic                                    req_n;
    logic                                    req_oe;
    logic [1:0]                              gap;
    logic                                    park_oe;
    logic                                    claim;
    logic                                    s66_oe;
    logic                                    cap66;
    logic [1:0]                              ctrl;
    logic [pci_side_pkg::NUM_EVENTS-1:0]     events;
    logic [31:0]                             rdata;
    logic                                    frame_prev;
  } state_t;

  localparam state_t STATE_RESET = '{
    lock_st:    pci_side_pkg::lock_idle,
    lock_n:     1'b1,
    perr_n:     1'b1,
    req_n:      1'b1,
    ctrl:       pci_side_pkg::CONTROL_RESET,
    events:     pci_side_pkg::EVENTS_RESET,
    frame_prev: 1'b1,
    default:    '0
  };

  state_t                              st;
  state_t                              next_st;
  logic [3:0]                          slow_sync;
  logic                                parity_bad;
  logic                                sec_serr;
  logic                                speed_sync;
  logic                                strap_sync;
  logic                                mode_sync;
  logic                                addr_phase;
  logic                                data_xfer;
  logic                                bus_idle;
  logic [pci_side_pkg::NUM_EVENTS-1:0] ev_set;
  logic [pci_side_pkg::NUM_EVENTS-1:0] ev_clear;
  logic                                serr_trigger;

  if (ADDR_W < 8)
  begin : g_bad_addr
    $error("register address must be at least eight bits");
  end

  // error pin resets to its idle high level, no false event after reset
  bit_sync #(
    .WIDTH     (4),
    .RESET_VAL (4'h1)
  ) u_slow_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in ({clock_mode_sync, speed_config_strap,
                primary_speed_enable, secondary_system_err_n}),
    .sync_out (slow_sync)
  );

  even_parity_check #(
    .DATA_W (32),
    .CBE_W  (4)
  ) u_parity (
    .ad         (st.chk_ad),
    .cbe        (st.chk_cbe),
    .par        (primary_parity),
    .parity_bad (parity_bad)
  );

  assign sec_serr   = !slow_sync[0];
  assign speed_sync = slow_sync[1];
  assign strap_sync = slow_sync[2];
  assign mode_sync  = slow_sync[3];
  assign addr_phase = !primary_frame_n && st.frame_prev && primary_irdy_n;
  assign data_xfer  = !primary_irdy_n && !primary_trdy_n && receiving_data;
  assign bus_idle   = primary_frame_n && primary_irdy_n;

  always_comb
  begin
    ev_set = '0;
    ev_set[pci_side_pkg::EV_ADDR_PAR]   = st.chk_valid && st.chk_addr
                                          && parity_bad;
    ev_set[pci_side_pkg::EV_PW_PAR]     = posted_write_parity_err;
    ev_set[pci_side_pkg::EV_SEC_SERR]   = sec_serr;
    ev_set[pci_side_pkg::EV_PW_MABORT]  = posted_write_master_abort;
    ev_set[pci_side_pkg::EV_PW_TABORT]  = posted_write_target_abort;
    ev_set[pci_side_pkg::EV_PW_DISCARD] = posted_write_discarded;
    ev_set[pci_side_pkg::EV_DW_DISCARD] = delayed_write_discarded;
    ev_set[pci_side_pkg::EV_DR_DISCARD] = delayed_read_discarded;
    ev_set[pci_side_pkg::EV_DT_TIMEOUT] = delayed_master_timeout;
    ev_set[pci_side_pkg::EV_DATA_PAR]   = st.chk_valid && !st.chk_addr
                                          && parity_bad;
  end

  assign ev_clear = (reg_write && reg_addr[7:0] == pci_side_pkg::REG_EVENTS)
                    ? reg_wdata[pci_side_pkg::NUM_EVENTS-1:0] : '0;
  assign serr_trigger = st.ctrl[pci_side_pkg::CTRL_SERR_EN]
                        && (|ev_set[pci_side_pkg::EV_DT_TIMEOUT:0]);

  always_comb
  begin
    next_st = st;
    next_st.frame_prev = primary_frame_n;
    // capture lines of an address phase or a received data phase
    next_st.chk_valid = addr_phase || data_xfer;
    next_st.chk_addr  = addr_phase;
    if (addr_phase || data_xfer)
    begin
      next_st.chk_ad  = primary_ad;
      next_st.chk_cbe = primary_cmd_byte_en;
    end
    // type 0 configuration claim
    next_st.claim = addr_phase && primary_config_select
                    && primary_ad[1:0] == pci_side_pkg::CFG_TYPE0
                    && (primary_cmd_byte_en == pci_side_pkg::CMD_CFG_READ
                     || primary_cmd_byte_en == pci_side_pkg::CMD_CFG_WRITE);
    // parity error: low one clock, high one clock, then released
    if (ev_set[pci_side_pkg::EV_DATA_PAR]
        && st.ctrl[pci_side_pkg::CTRL_PERR_EN])
    begin
      next_st.perr_n  = 1'b0;
      next_st.perr_oe = 1'b1;
    end
    else if (st.perr_oe && !st.perr_n)
    begin
      next_st.perr_n  = 1'b1;
      next_st.perr_oe = 1'b1;
    end
    else
    begin
      next_st.perr_n  = 1'b1;
      next_st.perr_oe = 1'b0;
    end
    // open drain: enable only, level held low
    next_st.serr_oe = serr_trigger;
    // request with minimum high gap
    next_st.req_oe = 1'b1;
    if (!st.req_n)
    begin
      if (!bus_request)
      begin
        next_st.req_n = 1'b1;
        next_st.gap   = pci_side_pkg::REQ_GAP_CYCLES - 2'h1;
      end
    end
    else if (st.gap != 2'h0)
    begin
      next_st.gap = st.gap - 2'h1;
    end
    else if (bus_request)
    begin
      next_st.req_n = 1'b0;
    end
    // park on idle bus with grant
    next_st.park_oe = bus_idle && !primary_grant_n;
    // lock sequence
    unique case (st.lock_st)
      pci_side_pkg::lock_idle:
      begin
        if (lock_request && master_active)
        begin
          next_st.lock_st = pci_side_pkg::lock_held;
          next_st.lock_n  = 1'b0;
          next_st.lock_oe = 1'b1;
        end
      end
      pci_side_pkg::lock_held:
      begin
        if (!lock_request)
        begin
          next_st.lock_st = pci_side_pkg::lock_release;
          next_st.lock_n  = 1'b1;
        end
      end
      pci_side_pkg::lock_release:
      begin
        next_st.lock_st = pci_side_pkg::lock_idle;
        next_st.lock_oe = 1'b0;
      end
      default:
      begin
        next_st.lock_st = pci_side_pkg::lock_idle;
        next_st.lock_n  = 1'b1;
        next_st.lock_oe = 1'b0;
      end
    endcase
    // speed selection
    next_st.s66_oe = mode_sync && !speed_sync;
    next_st.cap66  = mode_sync ? strap_sync : speed_sync;
    // registers: set wins over clear
    next_st.events = (st.events & ~ev_clear) | ev_set;
    if (reg_write && reg_addr[7:0] == pci_side_pkg::REG_CONTROL)
    begin
      next_st.ctrl = reg_wdata[1:0];
    end
    next_st.rdata = '0;
    if (reg_read)
    begin
      unique case (reg_addr[7:0])
        pci_side_pkg::REG_STATUS_CMD:
          next_st.rdata[pci_side_pkg::CAP66_BIT] = st.cap66;
        pci_side_pkg::REG_CONTROL:
          next_st.rdata[1:0] = st.ctrl;
        pci_side_pkg::REG_EVENTS:
          next_st.rdata[pci_side_pkg::NUM_EVENTS-1:0] = st.events;
        default:
          next_st.rdata = '0;
      endcase
    end
  end

  // primary reset clears every enable without a clock edge
  always_ff @(posedge core_clk or negedge primary_reset_n)
  begin
    if (!primary_reset_n)
    begin
      st <= STATE_RESET;
    end
    else if (!rst_n)
    begin
      st <= STATE_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign reg_rdata                  = st.rdata;
  assign primary_lock_n             = st.lock_n;
  assign primary_lock_oe            = st.lock_oe;
  assign primary_data_parity_err_n  = st.perr_n;
  assign primary_data_parity_err_oe = st.perr_oe;
  assign primary_system_err_n       = 1'b0;
  assign primary_system_err_oe      = st.serr_oe;
  assign primary_request_n          = st.req_n;
  assign primary_request_oe         = st.req_oe;
  assign primary_park_oe            = st.park_oe;
  assign config_claim               = st.claim;
  assign secondary_speed_enable     = 1'b0;
  assign secondary_speed_enable_oe  = st.s66_oe;
  assign status_cap66               = st.cap66;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n || !primary_reset_n);

  perr_two_clocks_a: assert property (
    data_xfer && st.ctrl[pci_side_pkg::CTRL_PERR_EN] ##1 parity_bad
    |=> !primary_data_parity_err_n && primary_data_parity_err_oe)
    else $error("parity error not driven two clocks after phase");
  perr_release_a: assert property (
    $fell(primary_data_parity_err_oe)
    |-> $past(primary_data_parity_err_n))
    else $error("parity error released without high cycle");
  req_gap_a: assert property (
    $rose(primary_request_n) |=> primary_request_n)
    else $error("request reasserted within two cycles");
  req_cause_a: assert property (
    $fell(primary_request_n) |-> $past(bus_request))
    else $error("request asserted without need");
  serr_cause_a: assert property (
    primary_system_err_oe |-> $past(|ev_set[8:0]))
    else $error("system error without cause");
  serr_event_a: assert property (
    st.ctrl[1] && delayed_master_timeout |=> primary_system_err_oe)
    else $error("timeout did not raise system error");
  config_claim_a: assert property (
    config_claim |-> $past(primary_config_select) && $past(addr_phase))
    else $error("config claimed without select");
  park_idle_a: assert property (
    primary_park_oe |-> $past(!primary_grant_n && bus_idle))
    else $error("park without grant on idle bus");
  lock_hold_a: assert property (
    !primary_lock_n && primary_lock_oe |-> $past(lock_request))
    else $error("lock held without request");
  cap66_mode_a: assert property (
    $past(mode_sync) && $past(primary_reset_n)
    |-> status_cap66 == $past(strap_sync))
    else $error("capability bit ignores strap in sync mode");
  speed_force_a: assert property (
    secondary_speed_enable_oe |-> $past(mode_sync && !speed_sync))
    else $error("secondary speed forced wrongly");

  perr_pulse_c: cover property (!primary_data_parity_err_n ##1
    primary_data_parity_err_n ##1 !primary_data_parity_err_oe);
  serr_pulse_c: cover property (primary_system_err_oe);
  lock_cycle_c: cover property (!primary_lock_n ##1 primary_lock_n
    ##1 !primary_lock_oe);
  req_cycle_c: cover property (!primary_request_n ##1
    primary_request_n [*2] ##1 !primary_request_n);
endmodule

// file: include/pci_side_pkg.sv
// shared constants and types of the primary-side control block
package pci_side_pkg;
  localparam logic [7:0]  REG_STATUS_CMD = 8'h04;
  localparam logic [7:0]  REG_CONTROL    = 8'h40;
  localparam logic [7:0]  REG_EVENTS     = 8'h44;
  localparam int          CAP66_BIT      = 21;
  localparam int          CTRL_PERR_EN   = 0;
  localparam int          CTRL_SERR_EN   = 1;
  localparam logic [1:0]  CONTROL_RESET  = 2'h3;
  localparam logic [9:0]  EVENTS_RESET   = 10'h000;
  localparam int          NUM_EVENTS     = 10;
  localparam int          EV_ADDR_PAR    = 0;
  localparam int          EV_PW_PAR      = 1;
  localparam int          EV_SEC_SERR    = 2;
  localparam int          EV_PW_MABORT   = 3;
  localparam int          EV_PW_TABORT   = 4;
  localparam int          EV_PW_DISCARD  = 5;
  localparam int          EV_DW_DISCARD  = 6;
  localparam int          EV_DR_DISCARD  = 7;
  localparam int          EV_DT_TIMEOUT  = 8;
  localparam int          EV_DATA_PAR    = 9;
  localparam logic [1:0]  REQ_GAP_CYCLES = 2'h2;
  localparam logic [3:0]  CMD_CFG_READ   = 4'ha;
  localparam logic [3:0]  CMD_CFG_WRITE  = 4'hb;
  localparam logic [1:0]  CFG_TYPE0      = 2'h0;
  localparam int          SYNC_STAGES    = 2;

  typedef enum logic [2:0] {
    lock_idle    = 3'b001,
    lock_held    = 3'b010,
    lock_release = 3'b100
  } lock_state_t;
endpackage

// file: hw/bit_sync.sv
// two-flop synchroniser for slow pins and straps
`timescale 1ns/1ps
module bit_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("bit_sync width must be at least one");
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      stage    <= RESET_VAL;
      sync_out <= RESET_VAL;
    end
    else
    begin
      stage    <= async_in;
      sync_out <= stage;
    end
  end
endmodule

// file: hw/even_parity_check.sv
// even parity check over address/data, command/byte enables and parity
`timescale 1ns/1ps
module even_parity_check #(
  parameter int DATA_W = 32,
  parameter int CBE_W  = 4
) (
  input  wire logic [DATA_W-1:0] ad,
  input  wire logic [CBE_W-1:0]  cbe,
  input  wire logic              par,
  output logic                   parity_bad
);
  if (DATA_W < 1 || CBE_W < 1)
  begin : g_bad_width
    $error("even_parity_check widths must be positive");
  end

  // an odd count of ones across all lines is an error
  assign parity_bad = ^{ad, cbe, par};
endmodule

// file: testbench/pci_host_model.sv
// primary bus far side: arbiter, pull-up lines, primary bus speed enable pin
`timescale 1ns/1ps
module pci_host_model (
  input  wire logic       core_clk,
  input  wire logic       request_n,
  input  wire logic       request_oe,
  input  wire logic       park_grant,
  input  wire logic [1:0] grant_wait,
  input  wire logic       serr_n,
  input  wire logic       serr_oe,
  input  wire logic       perr_n,
  input  wire logic       perr_oe,
  input  wire logic       speed_66,
  output logic            grant_n,
  output logic            serr_wire,
  output logic            perr_wire,
  output logic            speed_pin
);
  logic [1:0] wait_cnt = 2'h0;
  // shared line, pull-up restores high when nobody pulls low
  assign serr_wire = serr_oe ? serr_n : 1'b1;
  assign perr_wire = perr_oe ? perr_n : 1'b1;
  assign speed_pin = speed_66;
  initial grant_n = 1'b1;
  // grant after a chosen wait, or park the bus on the bridge
  always @(posedge core_clk)
  begin
    if (request_oe && !request_n && wait_cnt != grant_wait)
      wait_cnt <= wait_cnt + 2'h1;
    if (!(request_oe && !request_n))
      wait_cnt <= 2'h0;
    grant_n <= !(park_grant || (request_oe && !request_n
                 && wait_cnt == grant_wait));
  end
endmodule

// file: testbench/primary_side_control_tb.sv
// self-checking bench for the primary-side control block
`timescale 1ns/1ps
module primary_side_control_tb;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        primary_reset_n = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [31:0] primary_ad = 32'h0;
  logic [3:0]  primary_cmd_byte_en = 4'h0;
  logic        primary_parity = 1'b0;
  logic        primary_frame_n = 1'b1;
  logic        primary_irdy_n = 1'b1;
  logic        primary_trdy_n = 1'b1;
  logic        primary_config_select = 1'b0;
  logic        receiving_data = 1'b1;
  logic        bus_request = 1'b0;
  logic        master_active = 1'b0;
  logic        lock_request = 1'b0;
  logic [6:0]  ev = 7'h00;
  logic        secondary_system_err_n = 1'b1;
  logic        speed_config_strap = 1'b0;
  logic        clock_mode_sync = 1'b0;
  logic        park_grant = 1'b0;
  logic        speed_66 = 1'b0;
  logic [1:0]  grant_wait = 2'h2;
  logic [31:0] reg_rdata;
  logic        primary_grant_n, primary_speed_enable, serr_wire, perr_wire;
  logic        primary_lock_n, primary_lock_oe, primary_park_oe;
  logic        primary_data_parity_err_n, primary_data_parity_err_oe;
  logic        primary_system_err_n, primary_system_err_oe;
  logic        primary_request_n, primary_request_oe, config_claim;
  logic        secondary_speed_enable, secondary_speed_enable_oe;
  logic        status_cap66;
  int          mismatches = 0, cmp_count = 0, cycles = 0;

  primary_side_control dut (
    .core_clk, .rst_n, .primary_reset_n, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .primary_ad, .primary_cmd_byte_en,
    .primary_parity, .primary_frame_n, .primary_irdy_n, .primary_trdy_n,
    .primary_config_select, .primary_grant_n, .receiving_data,
    .bus_request, .master_active, .lock_request,
    .posted_write_parity_err(ev[0]),
    .posted_write_master_abort(ev[1]),
    .posted_write_target_abort(ev[2]),
    .posted_write_discarded(ev[3]),
    .delayed_write_discarded(ev[4]),
    .delayed_read_discarded(ev[5]),
    .delayed_master_timeout(ev[6]),
    .secondary_system_err_n, .primary_speed_enable, .speed_config_strap,
    .clock_mode_sync, .primary_lock_n, .primary_lock_oe,
    .primary_data_parity_err_n, .primary_data_parity_err_oe,
    .primary_system_err_n, .primary_system_err_oe, .primary_request_n,
    .primary_request_oe, .primary_park_oe, .config_claim,
    .secondary_speed_enable, .secondary_speed_enable_oe, .status_cap66
  );

  pci_host_model host (
    .core_clk, .request_n(primary_request_n),
    .request_oe(primary_request_oe), .park_grant, .grant_wait,
    .serr_n(primary_system_err_n), .serr_oe(primary_system_err_oe),
    .perr_n(primary_data_parity_err_n),
    .perr_oe(primary_data_parity_err_oe), .speed_66,
    .grant_n(primary_grant_n), .serr_wire, .perr_wire,
    .speed_pin(primary_speed_enable)
  );

  always #12.5 core_clk = ~core_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cycles++;
    if (primary_system_err_oe === 1'b1)
      check(primary_system_err_n, 1'b0);
    if (cycles == 20000)
    begin
      mismatches++;
      finish_test();
    end
  end

  function automatic logic par_of(input logic [31:0] a, input logic [3:0] c);
    return ^{a, c};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    @(negedge core_clk);
    check(reg_rdata, exp);
  endtask

  task automatic data_phase(input logic bad);
    @(posedge core_clk);
    primary_ad <= 32'h000000f1;
    primary_cmd_byte_en <= 4'h6;
    {primary_irdy_n, primary_trdy_n} <= 2'h0;
    @(posedge core_clk);
    {primary_irdy_n, primary_trdy_n} <= 2'h3;
    primary_parity <= par_of(32'h000000f1, 4'h6) ^ bad;
    @(posedge core_clk);
    @(negedge core_clk);
  endtask

  task automatic addr_phase(input logic [31:0] a, input logic [3:0] c,
                            input logic sel, bad, exp);
    @(posedge core_clk);
    {primary_frame_n, primary_irdy_n} <= 2'h1;
    primary_ad <= a;
    primary_cmd_byte_en <= c;
    primary_config_select <= sel;
    @(posedge core_clk);
    {primary_frame_n, primary_irdy_n} <= 2'h2;
    primary_parity <= par_of(a, c) ^ bad;
    primary_config_select <= 1'b0;
    @(negedge core_clk);
    check(config_claim, exp);
    @(posedge core_clk);
    primary_irdy_n <= 1'b1;
    @(negedge core_clk);
    check(config_claim, 1'b0);
  endtask

  task automatic t_parity();
    wr(8'h44, 32'h3ff);
    data_phase(1'b1);
    check({primary_data_parity_err_n, perr_wire}, 2'h0);
    @(negedge core_clk);
    check(primary_data_parity_err_n, 1'b1);
    check(primary_data_parity_err_oe, 1'b1);
    @(negedge core_clk);
    check({primary_data_parity_err_oe, perr_wire}, 2'h1);
    rd(8'h44, 32'h200);
    wr(8'h44, 32'h200);
    data_phase(1'b0);
    check(primary_data_parity_err_oe, 1'b0);
    @(posedge core_clk);
    receiving_data <= 1'b0;
    data_phase(1'b1);
    check(primary_data_parity_err_oe, 1'b0);
    @(posedge core_clk);
    receiving_data <= 1'b1;
    wr(8'h40, 32'h2);
    data_phase(1'b1);
    check(primary_data_parity_err_oe, 1'b0);
    rd(8'h44, 32'h200);
    wr(8'h40, 32'h3);
    wr(8'h44, 32'h3ff);
    $display("parity test done");
  endtask

  task automatic t_serr();
    logic hit;
    for (int i = 0; i < 7; i++)
    begin
      @(posedge core_clk);
      ev[i] <= 1'b1;
      @(posedge core_clk);
      ev[i] <= 1'b0;
      @(negedge core_clk);
      check({primary_system_err_oe, serr_wire}, 2'h2);
      @(negedge core_clk);
      check({primary_system_err_oe, serr_wire}, 2'h1);
    end
    rd(8'h44, 32'h1fa);
    wr(8'h44, 32'h1fa);
    rd(8'h44, 32'h0);
    @(posedge core_clk);
    secondary_system_err_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    secondary_system_err_n <= 1'b1;
    hit = 1'b0;
    repeat (6) @(negedge core_clk) hit |= primary_system_err_oe;
    check(hit, 1'b1);
    addr_phase(32'h10000000, 4'h7, 1'b0, 1'b1, 1'b0);
    hit = primary_system_err_oe;
    repeat (4) @(negedge core_clk) hit |= primary_system_err_oe;
    check({hit, primary_data_parity_err_oe}, 2'h2);
    rd(8'h44, 32'h5);
    wr(8'h44, 32'h3ff);
    wr(8'h40, 32'h1);
    @(posedge core_clk);
    ev[6] <= 1'b1;
    @(posedge core_clk);
    ev[6] <= 1'b0;
    repeat (2) @(negedge core_clk) check(primary_system_err_oe, 1'b0);
    rd(8'h44, 32'h100);
    wr(8'h40, 32'h3);
    wr(8'h44, 32'h3ff);
    $display("system error test done");
  endtask

  task automatic t_request();
    int n;
    check(primary_request_oe, 1'b1);
    @(posedge core_clk);
    bus_request <= 1'b1;
    @(posedge core_clk);
    bus_request <= 1'b0;
    @(negedge core_clk);
    check(primary_request_n, 1'b0);
    @(posedge core_clk);
    bus_request <= 1'b1;
    @(negedge core_clk);
    check(primary_request_n, 1'b1);
    @(negedge core_clk);
    check(primary_request_n, 1'b1);
    n = 0;
    while (primary_request_n !== 1'b0 && n < 4)
    begin
      @(negedge core_clk);
      n++;
    end
    check(primary_request_n, 1'b0);
    n = 0;
    while (primary_park_oe !== 1'b1 && n < 8)
    begin
      @(negedge core_clk);
      n++;
    end
    check(primary_park_oe, 1'b1);
    @(posedge core_clk);
    bus_request <= 1'b0;
    park_grant <= 1'b1;
    repeat (4) @(negedge core_clk);
    check(primary_park_oe, 1'b1);
    @(posedge core_clk);
    primary_frame_n <= 1'b0;
    repeat (2) @(negedge core_clk);
    check(primary_park_oe, 1'b0);
    @(posedge core_clk);
    primary_frame_n <= 1'b1;
    park_grant <= 1'b0;
    repeat (4) @(negedge core_clk);
    check(primary_park_oe, 1'b0);
    $display("request and park test done");
  endtask

  task automatic t_lock_cfg();
    @(posedge core_clk);
    master_active <= 1'b1;
    lock_request <= 1'b1;
    @(posedge core_clk);
    repeat (3) @(negedge core_clk) check({primary_lock_n, primary_lock_oe},
                                         2'h1);
    @(posedge core_clk);
    lock_request <= 1'b0;
    master_active <= 1'b0;
    @(negedge core_clk);
    check({primary_lock_n, primary_lock_oe}, 2'h1);
    @(negedge core_clk);
    check({primary_lock_n, primary_lock_oe}, 2'h3);
    @(negedge core_clk);
    check(primary_lock_oe, 1'b0);
    addr_phase(32'h00000100, 4'ha, 1'b1, 1'b0, 1'b1);
    addr_phase(32'h00000100, 4'hb, 1'b1, 1'b0, 1'b1);
    addr_phase(32'h00000100, 4'ha, 1'b0, 1'b0, 1'b0);
    addr_phase(32'h00000101, 4'ha, 1'b1, 1'b0, 1'b0);
    addr_phase(32'h00000100, 4'h6, 1'b1, 1'b0, 1'b0);
    $display("lock and config test done");
  endtask

  task automatic t_speed();
    logic cap;
    for (int k = 0; k < 8; k++)
    begin
      @(posedge core_clk);
      {clock_mode_sync, speed_66, speed_config_strap} <= 3'(k);
      repeat (5) @(negedge core_clk);
      cap = clock_mode_sync ? speed_config_strap : speed_66;
      check(status_cap66, cap);
      check(secondary_speed_enable_oe,
            clock_mode_sync & !speed_66);
      check(secondary_speed_enable, 1'b0);
      rd(8'h04, {10'h0, cap, 21'h0});
    end
    $display("speed test done");
  endtask

  task automatic t_pin_reset();
    @(posedge core_clk);
    master_active <= 1'b1;
    lock_request <= 1'b1;
    bus_request <= 1'b1;
    park_grant <= 1'b1;
    repeat (4) @(posedge core_clk);
    primary_reset_n <= 1'b0;
    #1;
    check({primary_lock_oe, primary_request_oe, primary_park_oe,
           primary_data_parity_err_oe, primary_system_err_oe,
           secondary_speed_enable_oe}, 6'h00);
    @(posedge core_clk);
    {master_active, lock_request, bus_request, park_grant} <= 4'h0;
    primary_reset_n <= 1'b1;
    repeat (2) @(negedge core_clk);
    check(primary_request_oe, 1'b1);
    $display("pin reset test done");
  endtask

  initial
  begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(8'h40, 32'h3);
    rd(8'h44, 32'h0);
    rd(8'h80, 32'h0);
    $display("register test done");
    t_parity();
    t_serr();
    t_request();
    t_lock_cfg();
    t_speed();
    t_pin_reset();
    finish_test();
  end
endmodule
